// *** rtl/dual_timer_regs.vh ***
// Register offsets, field positions and reset values of the dual timer block
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

`define ADR_FIRST_MODE      8'h00
`define ADR_FIRST_COUNT     8'h04
`define ADR_RUN_CTRL        8'h08
`define ADR_IRQ_FLAG        8'h0C
`define ADR_IRQ_ENABLE      8'h10
`define ADR_SECOND_CTRL_A   8'h14
`define ADR_SECOND_CTRL_B   8'h18
`define ADR_SECOND_COUNT    8'h1C
`define ADR_SECOND_PRESC    8'h20
`define ADR_PULSE_DUTY      8'h24
`define ADR_BUZZER_CTRL     8'h28
`define ADR_PIN_CONFIG      8'h2C

`define BIT_SLOW_ROUTE      7
`define BIT_FIRST_SRC       5
`define BIT_FIRST_EDGE      4
`define BIT_PRESC_OWNER     3
`define BIT_TIMER0_RUN      0
`define BIT_GLOBAL_IRQ      7
`define BIT_FIRST_FLAG      0
`define BIT_SECOND_FLAG     3
`define BIT_PULSE_EN        7
`define BIT_PULSE_AL        6
`define BIT_ONE_SHOT        2
`define BIT_RELOAD_SEL      1
`define BIT_SECOND_RUN      0
`define BIT_SECOND_SRC      5
`define BIT_SECOND_EDGE     4
`define BIT_PRESC1_EN_N     3
`define BIT_BUZZER_EN       7
`define BIT_BUZZER_SRC      3
`define BIT_CFG_ASYNC       0
`define BIT_CFG_BUZZER      1

`define RST_FIRST_MODE      8'h08
`define RST_SECOND_CTRL_B   8'h08
`define RST_BYTE            8'h00
`define RST_SECOND_COUNT    8'hFF
`define ONES_BYTE           8'hFF
`define ZERO_BYTE           8'h00

`endif

// *** rtl/dual_timer_pwm_buzzer.v ***
// Two 8-bit timers with pulse-width and buzzer output behind a Wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_regs.vh"

// Summary of operation
// - First timer counts up source or prescaled ticks while running
// - Write loads first count, read returns live
// - Source: instruction clock, count pin or slow oscillator
// - Edge select: one means falling, zero rising
// - Owner zero divides source; writing zero clears prescaler
// - Three-bit ratio divides by two up to 256
// - Synchronised to instruction clock unless async option
// - Overflow sets sticky flag, gated interrupt request
// - Second timer counts down; write loads reload too
// - Runs when enabled; source pin or instruction clock
// - Pin edge select: one falling, zero rising
// - Own prescaler active-low enable, ratio, readable value
// - One-shot counts once to zero then stops
// - Free-running restarts from reload or 0xFF
// - Underflow sets sticky flag, gated interrupt request
// - Pulse enable plus pin config drives pin
// - Polarity bit one makes pulse active low
// - Active clocks equal duty; frame follows reload
// - Buzzer enable plus pin config drives pin
// - Buzzer source prescaler or timer, divided select
module dual_timer_pwm_buzzer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        inst_tick_i,
    input  wire        ext_count_clock_i,
    input  wire        low_speed_rc_osc_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         irq_o,
    output reg         shared_port_pin_o,
    output reg         shared_port_pin_oe_n_o
);

    // Mask of ratio+1 low bits all ones gives a 2^(ratio+1) division
    function ratio_hit;
        input [7:0] cnt;
        input [2:0] ratio;
        reg   [7:0] mask;
        begin
            mask = `ONES_BYTE >> (3'h7 - ratio);
            ratio_hit = ((cnt & mask) == mask);
        end
    endfunction

    wire [1:0] pin_raw;
    reg  [1:0] sync1_q;
    reg  [1:0] sync2_q;

    assign pin_raw = {low_speed_rc_osc_i, ext_count_clock_i};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sync
            always @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end else if (ce_i) begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    wire       ext_lvl;
    wire       lrc_lvl;
    assign ext_lvl = sync2_q[0];
    assign lrc_lvl = sync2_q[1];

    reg  [7:0] mode_q;
    reg  [7:0] count0_q;
    reg        run0_q;
    reg        gie_q;
    reg        flag0_q;
    reg        flag1_q;
    reg        ien0_q;
    reg        ien1_q;
    reg  [7:0] ctrl_a_q;
    reg  [7:0] ctrl_b_q;
    reg  [7:0] count1_q;
    reg  [7:0] reload_q;
    reg  [7:0] presc0_q;
    reg  [7:0] presc1_q;
    reg  [7:0] duty_q;
    reg  [7:0] bz_ctrl_q;
    reg  [7:0] bz_div_q;
    reg        bz_q;
    reg        cfg_async_q;
    reg        cfg_buzzer_q;
    reg        done1_q;
    reg        samp0_q;
    reg        last0_q;
    reg        last1_q;

    // Bus decode; writes land at the edge that raises ack
    wire       req;
    wire       wr;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i & wb_sel_i[0];

    wire       wr_mode;
    wire       wr_count0;
    wire       wr_run;
    wire       wr_flag;
    wire       wr_ien;
    wire       wr_ctrl_a;
    wire       wr_ctrl_b;
    wire       wr_count1;
    wire       wr_duty;
    wire       wr_bz;
    wire       wr_cfg;
    wire [7:0] wd;
    assign wd        = wb_dat_i[7:0];
    assign wr_mode   = wr & (wb_adr_i == `ADR_FIRST_MODE);
    assign wr_count0 = wr & (wb_adr_i == `ADR_FIRST_COUNT);
    assign wr_run    = wr & (wb_adr_i == `ADR_RUN_CTRL);
    assign wr_flag   = wr & (wb_adr_i == `ADR_IRQ_FLAG);
    assign wr_ien    = wr & (wb_adr_i == `ADR_IRQ_ENABLE);
    assign wr_ctrl_a = wr & (wb_adr_i == `ADR_SECOND_CTRL_A);
    assign wr_ctrl_b = wr & (wb_adr_i == `ADR_SECOND_CTRL_B);
    assign wr_count1 = wr & (wb_adr_i == `ADR_SECOND_COUNT);
    assign wr_duty   = wr & (wb_adr_i == `ADR_PULSE_DUTY);
    assign wr_bz     = wr & (wb_adr_i == `ADR_BUZZER_CTRL);
    assign wr_cfg    = wr & (wb_adr_i == `ADR_PIN_CONFIG);

    // First timer source and edge
    wire       src0_sel;
    wire       lvl0;
    wire       samp_en0;
    wire       edge0;
    wire       tick_src0;
    wire       owner;
    wire       presc0_tick;
    wire       tick0;
    wire       ovf0;
    assign src0_sel  = mode_q[`BIT_FIRST_SRC];
    assign lvl0      = mode_q[`BIT_SLOW_ROUTE] ? lrc_lvl : ext_lvl;
    // Sampling at instruction ticks drops pulses faster than them
    assign samp_en0  = cfg_async_q | inst_tick_i;
    assign edge0     = mode_q[`BIT_FIRST_EDGE] ? (last0_q & ~samp0_q)
                                               : (~last0_q & samp0_q);
    assign tick_src0 = src0_sel ? (edge0 & samp_en0) : inst_tick_i;
    assign owner     = mode_q[`BIT_PRESC_OWNER];
    assign presc0_tick = tick_src0 & ratio_hit(presc0_q, mode_q[2:0]);
    assign tick0     = owner ? tick_src0 : presc0_tick;
    assign ovf0      = run0_q & tick0 & (count0_q == `ONES_BYTE) & ~wr_count0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            samp0_q <= 1'b0;
            last0_q <= 1'b0;
        end else if (ce_i && samp_en0) begin
            samp0_q <= lvl0;
            last0_q <= samp0_q;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            presc0_q <= `RST_BYTE;
        end else if (ce_i) begin
            if (wr_mode && !wd[`BIT_PRESC_OWNER]) begin
                presc0_q <= `RST_BYTE;
            end else if (!owner && tick_src0) begin
                presc0_q <= presc0_q + 8'h01;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            count0_q <= `RST_BYTE;
        end else if (ce_i) begin
            if (wr_count0) begin
                count0_q <= wd;
            end else if (run0_q && tick0) begin
                count0_q <= count0_q + 8'h01;
            end
        end
    end

    // Second timer source, prescaler and down counter
    wire       edge1;
    wire       tick_src1;
    wire       presc1_on;
    wire       presc1_tick;
    wire       tick1;
    wire       run1;
    wire       unf1;
    assign edge1     = ctrl_b_q[`BIT_SECOND_EDGE] ? (last1_q & ~ext_lvl)
                                                  : (~last1_q & ext_lvl);
    assign tick_src1 = ctrl_b_q[`BIT_SECOND_SRC] ? edge1 : inst_tick_i;
    assign presc1_on = ~ctrl_b_q[`BIT_PRESC1_EN_N];
    assign presc1_tick = tick_src1 & ratio_hit(presc1_q, ctrl_b_q[2:0]);
    assign tick1     = presc1_on ? presc1_tick : tick_src1;
    assign run1      = ctrl_a_q[`BIT_SECOND_RUN] & ~done1_q;
    assign unf1      = run1 & tick1 & (count1_q == `ZERO_BYTE) & ~wr_count1;

    always @(posedge clk_i) begin
        if (rst_i) begin
            last1_q  <= 1'b0;
            presc1_q <= `RST_BYTE;
        end else if (ce_i) begin
            last1_q <= ext_lvl;
            if (presc1_on && tick_src1) begin
                presc1_q <= presc1_q + 8'h01;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            count1_q <= `RST_SECOND_COUNT;
            reload_q <= `RST_SECOND_COUNT;
            done1_q  <= 1'b0;
        end else if (ce_i) begin
            if (wr_count1) begin
                count1_q <= wd;
                reload_q <= wd;
                done1_q  <= 1'b0;
            end else if (unf1) begin
                if (ctrl_a_q[`BIT_ONE_SHOT]) begin
                    done1_q <= 1'b1;
                end else if (ctrl_a_q[`BIT_RELOAD_SEL]) begin
                    count1_q <= reload_q;
                end else begin
                    count1_q <= `ONES_BYTE;
                end
            end else if (run1 && tick1) begin
                count1_q <= count1_q - 8'h01;
            end
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            flag0_q <= 1'b0;
            flag1_q <= 1'b0;
        end else if (ce_i) begin
            flag0_q <= ovf0 | (flag0_q & ~(wr_flag & ~wd[`BIT_FIRST_FLAG]));
            flag1_q <= unf1 | (flag1_q & ~(wr_flag & ~wd[`BIT_SECOND_FLAG]));
        end
    end

    // Pulse width and buzzer
    wire       pulse_act;
    wire       pulse_lvl;
    wire       bz_src;
    wire       bz_tick;
    wire       pulse_drive;
    wire       bz_drive;
    // Count below duty gives exactly duty input clocks per frame
    assign pulse_act   = run1 & (count1_q < duty_q);
    assign pulse_lvl   = pulse_act ^ ctrl_a_q[`BIT_PULSE_AL];
    assign bz_src      = bz_ctrl_q[`BIT_BUZZER_SRC] ? unf1 : presc1_tick;
    assign bz_tick     = bz_src & ratio_hit(bz_div_q, bz_ctrl_q[2:0]);
    assign pulse_drive = ctrl_a_q[`BIT_PULSE_EN] & ~cfg_buzzer_q;
    assign bz_drive    = bz_ctrl_q[`BIT_BUZZER_EN] & cfg_buzzer_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            bz_div_q <= `RST_BYTE;
            bz_q     <= 1'b0;
        end else if (ce_i) begin
            if (!bz_ctrl_q[`BIT_BUZZER_EN]) begin
                bz_div_q <= `RST_BYTE;
                bz_q     <= 1'b0;
            end else begin
                if (bz_src) begin
                    bz_div_q <= bz_div_q + 8'h01;
                end
                if (bz_tick) begin
                    bz_q <= ~bz_q;
                end
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            shared_port_pin_o      <= 1'b0;
            shared_port_pin_oe_n_o <= 1'b1;
            irq_o                  <= 1'b0;
        end else if (ce_i) begin
            shared_port_pin_oe_n_o <= ~(pulse_drive | bz_drive);
            shared_port_pin_o      <= bz_drive ? bz_q : (pulse_drive & pulse_lvl);
            irq_o <= gie_q & ((flag0_q & ien0_q) | (flag1_q & ien1_q));
        end
    end

    // Software-written control registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_q       <= `RST_FIRST_MODE;
            run0_q       <= 1'b0;
            gie_q        <= 1'b0;
            ien0_q       <= 1'b0;
            ien1_q       <= 1'b0;
            ctrl_a_q     <= `RST_BYTE;
            ctrl_b_q     <= `RST_SECOND_CTRL_B;
            duty_q       <= `RST_BYTE;
            bz_ctrl_q    <= `RST_BYTE;
            cfg_async_q  <= 1'b0;
            cfg_buzzer_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_mode) begin
                mode_q <= {wd[7], 1'b0, wd[5:0]};
            end
            if (wr_run) begin
                run0_q <= wd[`BIT_TIMER0_RUN];
                gie_q  <= wd[`BIT_GLOBAL_IRQ];
            end
            if (wr_ien) begin
                ien0_q <= wd[`BIT_FIRST_FLAG];
                ien1_q <= wd[`BIT_SECOND_FLAG];
            end
            if (wr_ctrl_a) begin
                ctrl_a_q <= {wd[7:6], 3'h0, wd[2:0]};
            end
            if (wr_ctrl_b) begin
                ctrl_b_q <= {2'h0, wd[5:0]};
            end
            if (wr_duty) begin
                duty_q <= wd;
            end
            if (wr_bz) begin
                bz_ctrl_q <= {wd[7], 3'h0, wd[3:0]};
            end
            if (wr_cfg) begin
                cfg_async_q  <= wd[`BIT_CFG_ASYNC];
                cfg_buzzer_q <= wd[`BIT_CFG_BUZZER];
            end
        end
    end

    // Read mux; unmapped addresses answer with zero
    reg  [7:0] rd;
    always @* begin
        rd = `ZERO_BYTE;
        case (wb_adr_i)
            `ADR_FIRST_MODE:    rd = mode_q;
            `ADR_FIRST_COUNT:   rd = count0_q;
            `ADR_RUN_CTRL:      rd = {gie_q, 6'h00, run0_q};
            `ADR_IRQ_FLAG:      rd = {4'h0, flag1_q, 2'h0, flag0_q};
            `ADR_IRQ_ENABLE:    rd = {4'h0, ien1_q, 2'h0, ien0_q};
            `ADR_SECOND_CTRL_A: rd = ctrl_a_q;
            `ADR_SECOND_CTRL_B: rd = ctrl_b_q;
            `ADR_SECOND_COUNT:  rd = count1_q;
            `ADR_SECOND_PRESC:  rd = presc1_q;
            `ADR_PULSE_DUTY:    rd = duty_q;
            `ADR_BUZZER_CTRL:   rd = bz_ctrl_q;
            `ADR_PIN_CONFIG:    rd = {6'h00, cfg_buzzer_q, cfg_async_q};
            default:            rd = `ZERO_BYTE;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= {24'h000000, rd};
            end
        end
    end

endmodule
`default_nettype wire

// *** dv/dual_timer_monitor.sv ***
// Port checker for the dual timer block
`timescale 1ns/10ps
`default_nettype none
module dual_timer_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        shared_port_pin_o,
    input wire logic        shared_port_pin_oe_n_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic       take, drv, pidle, gate;
    logic [7:0] run_q, ien_q, cta_q, duty_q, bz_q, cfg_q;
    assign take  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    assign drv   = cfg_q[1] ? bz_q[7] : cta_q[7];
    assign pidle = cta_q[7] & ~cfg_q[1] & (~cta_q[0] | (duty_q == 8'h00));
    assign gate  = run_q[7] & (ien_q[0] | ien_q[3]);
    // Shadows of the control bits, captured at the edge where the slave takes the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {run_q, ien_q, cta_q, duty_q, bz_q, cfg_q} <= '0;
        end else if (take & wb_we_i & wb_sel_i[0]) begin
            case (wb_adr_i)
                8'h08: run_q <= wb_dat_i[7:0];
                8'h10: ien_q <= wb_dat_i[7:0];
                8'h14: cta_q <= wb_dat_i[7:0];
                8'h24: duty_q <= wb_dat_i[7:0];
                8'h28: bz_q <= wb_dat_i[7:0];
                8'h2C: cfg_q <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end
    AST_ACK_NEXT: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_UNMAPPED: assert property (take && !wb_we_i && wb_adr_i == 8'h30 |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    AST_FREEZE: assert property (!ce_i |=> $stable(irq_o) && $stable(shared_port_pin_o))
        else $error("outputs moved while frozen");
    AST_OE_DRIVE: assert property (drv && $past(drv) |-> !shared_port_pin_oe_n_o)
        else $error("pin not driven when enabled");
    AST_OE_RELEASE: assert property (!drv && $past(!drv) |-> shared_port_pin_oe_n_o)
        else $error("pin driven when disabled");
    AST_IRQ_GATE: assert property (irq_o |-> $past(gate) || $past(gate, 2))
        else $error("irq without enables");
    AST_PULSE_IDLE: assert property (pidle && $past(pidle) && $stable(cta_q[6])
        |-> shared_port_pin_o == cta_q[6])
        else $error("inactive pulse level wrong");
    COV_IRQ: cover property (irq_o);
    COV_PULSE: cover property (!shared_port_pin_oe_n_o && !cfg_q[1]);
    COV_BUZZ: cover property (!shared_port_pin_oe_n_o && cfg_q[1]);
endmodule
bind dual_timer_pwm_buzzer dual_timer_monitor i_mon (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .shared_port_pin_o, .shared_port_pin_oe_n_o);
`default_nettype wire

// *** dv/pin_partner.sv ***
// Model of the count pins and the loaded output pin
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
    input  wire logic clk_i,
    input  wire logic pin_i,
    input  wire logic oe_n_i,
    output var  logic ext_o,
    output var  logic slow_o,
    output wire logic pin_w_o
);
    // Pull-up holds the released pin high, so a stale level is never seen
    assign pin_w_o = oe_n_i ? 1'b1 : pin_i;
    initial begin
        ext_o = 1'b0;
        slow_o = 1'b0;
    end
    // Levels are held many clocks so the synchroniser never misses an edge
    task automatic drive(input logic s, input logic v);
        @(posedge clk_i);
        if (s) slow_o <= v;
        else ext_o <= v;
        repeat (6) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** dv/tb_dual_timer_pwm_buzzer.sv ***
// Register-level bench for the dual timer block
`timescale 1ns/10ps
`default_nettype none
module tb_dual_timer_pwm_buzzer;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, tick = 1'b0;
    logic        cyc = 1'b0, we = 1'b0, lp = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000, rdat;
    wire  [31:0] dat_o;
    wire         ack, irq, pin, oe_n, ext, slow, pin_w;
    int          err_count = 0, cmp_count = 0, hi = 0, tg = 0;
    dual_timer_pwm_buzzer i_dut (.clk_i, .rst_i, .ce_i, .inst_tick_i(tick), .ext_count_clock_i(ext),
        .low_speed_rc_osc_i(slow), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .shared_port_pin_o(pin), .shared_port_pin_oe_n_o(oe_n));
    pin_partner i_pin (.clk_i, .pin_i(pin), .oe_n_i(oe_n), .ext_o(ext), .slow_o(slow), .pin_w_o(pin_w));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("Checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    // The slave's latency is not assumed; only the bound cuts a hung bus short
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        cyc  <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("[ERR] bus_ack expected 1 seen %b", ack);
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, e, rdat[7:0]);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            repeat (3) @(posedge clk_i);
            hi += (pin_w === 1'b1);
            if (pin_w !== lp) tg++;
            lp = pin_w;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("mode", 8'h00, 8'h08);
        rd("ctrl_b", 8'h18, 8'h08);
        rd("count1", 8'h1C, 8'hFF);
        rd("unmapped", 8'h30, 8'h00);
        $display("reset test done");
        wr(8'h10, 8'h09);
        wr(8'h08, 8'h80);
        wr(8'h04, 8'hFD);
        tk(3);
        rd("stopped", 8'h04, 8'hFD);
        wr(8'h08, 8'h81);
        tk(3);
        rd("wrap", 8'h04, 8'h00);
        rd("flag0", 8'h0C, 8'h01);
        chk("irq", 8'h01, {7'h00, irq});
        wr(8'h0C, 8'hFF);
        rd("sticky", 8'h0C, 8'h01);
        wr(8'h0C, 8'h00);
        rd("cleared", 8'h0C, 8'h00);
        chk("irq_off", 8'h00, {7'h00, irq});
        $display("overflow test done");
        for (int r = 0; r < 8; r++) begin
            wr(8'h00, 8'(r));
            wr(8'h04, 8'h00);
            tk((2 << r) - 1);
            rd("presc_lo", 8'h04, 8'h00);
            tk(1);
            rd("presc", 8'h04, 8'h01);
        end
        $display("prescaler test done");
        wr(8'h2C, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, (i[1] ? 8'hA8 : 8'h28) | {3'h0, i[0], 4'h0});
            wr(8'h04, 8'h00);
            i_pin.drive(~i[1], 1'b1);
            i_pin.drive(~i[1], 1'b0);
            i_pin.drive(i[1], 1'b1);
            rd("src_rise", 8'h04, {7'h00, ~i[0]});
            i_pin.drive(i[1], 1'b0);
            rd("src_fall", 8'h04, 8'h01);
        end
        // Synchronised mode: a pin edge counts only once instruction ticks sample it
        wr(8'h2C, 8'h00);
        wr(8'h00, 8'h28);
        wr(8'h04, 8'h00);
        i_pin.drive(1'b0, 1'b1);
        rd("sync_hold", 8'h04, 8'h00);
        tk(2);
        rd("sync_tick", 8'h04, 8'h01);
        i_pin.drive(1'b0, 1'b0);
        $display("source test done");
        wr(8'h1C, 8'h03);
        wr(8'h14, 8'h05);
        tk(3);
        rd("one_pre", 8'h1C, 8'h00);
        rd("flag_pre", 8'h0C, 8'h00);
        tk(3);
        rd("one_shot", 8'h1C, 8'h00);
        rd("flag1", 8'h0C, 8'h08);
        wr(8'h0C, 8'h00);
        wr(8'h1C, 8'h02);
        wr(8'h14, 8'h03);
        tk(3);
        rd("reload", 8'h1C, 8'h02);
        wr(8'h14, 8'h01);
        tk(3);
        rd("to_ff", 8'h1C, 8'hFF);
        wr(8'h14, 8'h00);
        tk(2);
        rd("halted", 8'h1C, 8'hFF);
        wr(8'h18, 8'h00);
        wr(8'h1C, 8'h10);
        wr(8'h14, 8'h01);
        tk(4);
        rd("presc1", 8'h1C, 8'h0E);
        rd("presc1_val", 8'h20, 8'h04);
        wr(8'h18, 8'h38);
        wr(8'h1C, 8'h05);
        i_pin.drive(1'b0, 1'b1);
        rd("fall_wait", 8'h1C, 8'h05);
        i_pin.drive(1'b0, 1'b0);
        rd("fall_cnt", 8'h1C, 8'h04);
        wr(8'h18, 8'h28);
        i_pin.drive(1'b0, 1'b1);
        rd("rise_cnt", 8'h1C, 8'h03);
        $display("second timer test done");
        wr(8'h18, 8'h08);
        for (int i = 0; i < 4; i++) begin
            wr(8'h24, i[1] ? 8'h00 : 8'h02);
            wr(8'h1C, 8'h04);
            wr(8'h14, {1'b1, i[0], 6'h03});
            hi = 0;
            tk(10);
            chk("oe", 8'h00, {7'h00, oe_n});
            chk("active", i[1] ? 8'h00 : 8'h04, 8'(i[0] ? 10 - hi : hi));
        end
        $display("pulse test done");
        wr(8'h18, 8'h00);
        wr(8'h2C, 8'h02);
        wr(8'h28, 8'h80);
        tg = 0;
        // Let the pin leave its pull-up level before taking the baseline
        @(posedge clk_i);
        lp = pin_w;
        tk(64);
        chk("buzz", 8'h10, 8'(tg));
        @(posedge clk_i);
        ce_i <= 1'b0;
        tick <= 1'b1;
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
        tick <= 1'b0;
        rd("frozen", 8'h20, 8'h44);
        wr(8'h18, 8'h08);
        wr(8'h1C, 8'h01);
        wr(8'h28, 8'h88);
        tg = 0;
        @(posedge clk_i);
        lp = pin_w;
        tk(16);
        chk("buzz_tmr", 8'h04, 8'(tg));
        wr(8'h28, 8'h00);
        tk(1);
        chk("release", 8'h01, {7'h00, oe_n});
        $display("buzzer test done");
        close_out();
    end
endmodule
`default_nettype wire
